/* File: core/tmc_pkg.sv */
package tmc_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] TMC_OFF_CTRL_A  = 8'h00;
   localparam logic [7:0] TMC_OFF_CTRL_B  = 8'h04;
   localparam logic [7:0] TMC_OFF_CTRL_C  = 8'h08;
   localparam logic [7:0] TMC_OFF_COUNT   = 8'h0C;
   localparam logic [7:0] TMC_OFF_CMP_A   = 8'h10;
   localparam logic [7:0] TMC_OFF_CMP_B   = 8'h14;
   localparam logic [7:0] TMC_OFF_FLAG    = 8'h18;
   localparam logic [7:0] TMC_OFF_MASK    = 8'h1C;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int TMC_CA_WM0    = 0;
   localparam int TMC_CA_WM1    = 1;
   localparam int TMC_CA_COMB   = 4;
   localparam int TMC_CA_COMA   = 6;
   localparam int TMC_CB_CS     = 0;
   localparam int TMC_CB_WM2    = 3;
   localparam int TMC_CC_FOCB   = 6;
   localparam int TMC_CC_FOCA   = 7;
   localparam int TMC_FL_OVF    = 0;
   localparam int TMC_FL_CMPA   = 1;
   localparam int TMC_FL_CMPB   = 2;
   // ---------------------------------------------------------------
   // values
   // ---------------------------------------------------------------
   localparam logic [7:0] TMC_BOTTOM    = 8'h00;
   localparam logic [7:0] TMC_MAX       = 8'hFF;
   localparam logic [7:0] TMC_RST_BYTE  = 8'h00;
   localparam logic [2:0] TMC_CS_STOP   = 3'h0;
   localparam logic [2:0] TMC_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] TMC_CS_EXT_RISE = 3'h7;
   localparam logic [2:0] TMC_WM_NORMAL = 3'h0;
   localparam logic [2:0] TMC_WM_CTC    = 3'h2;
   localparam logic [2:0] TMC_WM_FAST   = 3'h3;
   localparam logic [2:0] TMC_WM_FAST_A = 3'h7;
   localparam logic [1:0] TMC_COM_OFF   = 2'h0;
   localparam logic [1:0] TMC_COM_TOG   = 2'h1;
   localparam logic [1:0] TMC_COM_CLR   = 2'h2;
   localparam logic [1:0] TMC_COM_SET   = 2'h3;
   localparam logic [9:0] TMC_DIV8      = 10'h007;
   localparam logic [9:0] TMC_DIV64     = 10'h03F;
   localparam logic [9:0] TMC_DIV256    = 10'h0FF;
   localparam logic [9:0] TMC_DIV1024   = 10'h3FF;
endpackage

/* File: core/tmc_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module tmc_tick (
   input  wire logic       pclk,         // system clock
   input  wire logic       presetn,      // async reset, low
   input  wire logic [2:0] clock_select, // source and edge
   input  wire logic       ext_count_pin, // external count pin
   output logic            timer_tick    // one-cycle enable
);
   import tmc_pkg::*;

   typedef struct packed {
      logic [9:0] pre;
      logic       s1;
      logic       s2;
      logic       s3;
      logic       tick;
   } tmc_tick_type;

   tmc_tick_type st_q, st_d;

   assign timer_tick = st_q.tick;

   // ---------------------------------------------------------------
   // prescaler and source select
   // ---------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      st_d.pre  = st_q.pre + 10'h001;
      st_d.s1   = ext_count_pin;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      unique case (clock_select)
         TMC_CS_STOP:     st_d.tick = 1'b0;
         3'h1:            st_d.tick = 1'b1;
         3'h2:            st_d.tick = (st_q.pre[2:0] == TMC_DIV8[2:0]);
         3'h3:            st_d.tick = (st_q.pre[5:0] == TMC_DIV64[5:0]);
         3'h4:            st_d.tick = (st_q.pre[7:0] == TMC_DIV256[7:0]);
         3'h5:            st_d.tick = (st_q.pre == TMC_DIV1024);
         TMC_CS_EXT_FALL: st_d.tick = st_q.s3 & ~st_q.s2;
         TMC_CS_EXT_RISE: st_d.tick = ~st_q.s3 & st_q.s2;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule
`default_nettype wire

/* File: core/tmc_timer.sv */
// Functional notes
// - counter and both compare values are 8-bit registers.
// - BOTTOM is zero, MAX is 0xFF, TOP is MAX or compare A.
// - tick comes from prescaler or external pin, chosen by clock select.
// - clock select zero stops the counter.
// - software may read and write the counter at any time.
// - a counter write beats any clear or count.
// - each tick clears or increments per mode.
// - three-bit wave mode, two bits in ctrl A, one in ctrl B.
// - counter compared with both compare values continuously.
// - match sets the channel flag on the next tick; mask gates interrupt.
// - compare flag clears on service or when software writes one.
// - flag register holds three sources, mask register masks each.
// - overflow flag set per wave mode and can interrupt.
// - in PWM modes compare accesses reach a buffer register.
// - PWM buffer copies to active compare only at TOP.
// - normal and clear-on-match modes access active compare directly.
// - force bit in non-PWM modes updates output only, no flag or clear.
// - counter write blocks matches in the following tick, even stopped.
// - output state kept across wave mode changes.
// - output mode bits are not buffered; they act at once.
// - normal mode counts up, wraps 0xFF to zero, overflow on zero.
// - clear-on-match mode clears counter at compare A.
// - fast PWM counts BOTTOM to TOP; TOP is 0xFF or compare A.
// - fast PWM non-inverting clears on match, sets at BOTTOM; inverting opposite.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer (
   input  wire logic        pclk,          // system clock
   input  wire logic        presetn,       // async reset, low
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb direction
   input  wire logic [7:0]  paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire logic        ext_count_pin, // external count pin
   input  wire logic        int_ack_a,     // compare a serviced
   input  wire logic        int_ack_b,     // compare b serviced
   input  wire logic        int_ack_ovf,   // overflow serviced
   output logic             irq_ovf,       // overflow request
   output logic             irq_cmp_a,     // compare a request
   output logic             irq_cmp_b,     // compare b request
   output logic             wave_out_a,    // waveform a
   output logic             wave_out_b     // waveform b
);
   import tmc_pkg::*;

   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [7:0]  count_value;
      logic [1:0][7:0] cmp_act;
      logic [1:0][7:0] cmp_buf;
      logic [1:0]  out_st;
      logic [2:0]  flags;
      logic [2:0]  mask;
      logic        block;
      logic [1:0]  match_pend;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic [2:0]  irq;
   } tmc_timer_type;

   tmc_timer_type st_q, st_d;
   logic          timer_tick;

   tmc_tick u_tick (
      .pclk          (pclk),
      .presetn       (presetn),
      .clock_select  (st_q.ctrl_b[TMC_CB_CS +: 3]),
      .ext_count_pin (ext_count_pin),
      .timer_tick    (timer_tick)
   );

   assign prdata     = st_q.rdata;
   assign pready     = st_q.ready;
   assign pslverr    = st_q.err;
   assign irq_ovf    = st_q.irq[TMC_FL_OVF];
   assign irq_cmp_a  = st_q.irq[TMC_FL_CMPA];
   assign irq_cmp_b  = st_q.irq[TMC_FL_CMPB];
   assign wave_out_a = st_q.out_st[0];
   assign wave_out_b = st_q.out_st[1];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [2:0] wmode;
      logic       pwm;
      logic [7:0] top;
      logic       at_top;
      logic       acc;
      logic       wr;
      logic       cnt_wr;
      logic [1:0] match;
      logic [1:0] com;
      logic [2:0] set_fl;
      logic [2:0] clr_fl;
      logic       force_bit;
      wmode     = 3'h0;
      pwm       = 1'b0;
      top       = TMC_MAX;
      at_top    = 1'b0;
      acc       = 1'b0;
      wr        = 1'b0;
      cnt_wr    = 1'b0;
      match     = 2'b00;
      com       = 2'b00;
      set_fl    = 3'b000;
      clr_fl    = 3'b000;
      force_bit = 1'b0;
      st_d      = st_q;

      wmode = {st_q.ctrl_b[TMC_CB_WM2], st_q.ctrl_a[TMC_CA_WM1],
               st_q.ctrl_a[TMC_CA_WM0]};
      pwm   = (wmode == TMC_WM_FAST) || (wmode == TMC_WM_FAST_A);
      top   = (wmode == TMC_WM_CTC || wmode == TMC_WM_FAST_A) ?
              st_q.cmp_act[0] : TMC_MAX;
      at_top = (st_q.count_value == top);

      // bus: single wait state, answer on the second access cycle
      acc = psel && penable && !st_q.ready;
      wr  = acc && pwrite;
      st_d.ready = acc;
      st_d.err   = 1'b0;
      if (acc && !pwrite) begin
         st_d.rdata = 32'h0000_0000;
         unique case (paddr)
            TMC_OFF_CTRL_A: st_d.rdata[7:0] = st_q.ctrl_a;
            TMC_OFF_CTRL_B: st_d.rdata[7:0] = st_q.ctrl_b;
            TMC_OFF_CTRL_C: st_d.rdata[7:0] = TMC_RST_BYTE;
            TMC_OFF_COUNT:  st_d.rdata[7:0] = st_q.count_value;
            TMC_OFF_CMP_A:  st_d.rdata[7:0] = pwm ? st_q.cmp_buf[0] : st_q.cmp_act[0];
            TMC_OFF_CMP_B:  st_d.rdata[7:0] = pwm ? st_q.cmp_buf[1] : st_q.cmp_act[1];
            TMC_OFF_FLAG:   st_d.rdata[2:0] = st_q.flags;
            TMC_OFF_MASK:   st_d.rdata[2:0] = st_q.mask;
            default:        st_d.err = 1'b1;
         endcase
      end else if (wr) begin
         unique case (paddr)
            TMC_OFF_CTRL_A: st_d.ctrl_a = pwdata[7:0];
            TMC_OFF_CTRL_B: st_d.ctrl_b = pwdata[7:0];
            TMC_OFF_CTRL_C: force_bit = 1'b1;
            TMC_OFF_COUNT:  cnt_wr = 1'b1;
            TMC_OFF_CMP_A: begin
               st_d.cmp_buf[0] = pwdata[7:0];
               if (!pwm) begin
                  st_d.cmp_act[0] = pwdata[7:0];
               end
            end
            TMC_OFF_CMP_B: begin
               st_d.cmp_buf[1] = pwdata[7:0];
               if (!pwm) begin
                  st_d.cmp_act[1] = pwdata[7:0];
               end
            end
            TMC_OFF_FLAG:   clr_fl = pwdata[2:0];
            TMC_OFF_MASK:   st_d.mask = pwdata[2:0];
            default:        st_d.err = 1'b1;
         endcase
      end

      // compare: match is registered into the flag on the next tick
      match[0] = (st_q.count_value == st_q.cmp_act[0]);
      match[1] = (st_q.count_value == st_q.cmp_act[1]);

      if (timer_tick) begin
         set_fl[TMC_FL_CMPA] = st_q.match_pend[0];
         set_fl[TMC_FL_CMPB] = st_q.match_pend[1];
         // a counter write blocks matches of the tick that follows
         st_d.match_pend = st_q.block ? 2'b00 : match;
         st_d.block      = 1'b0;
         // counting; top in clear modes restarts at bottom
         if (wmode == TMC_WM_NORMAL || !(at_top)) begin
            st_d.count_value = st_q.count_value + 8'h01;
         end else begin
            st_d.count_value = TMC_BOTTOM;
         end
         if (st_q.count_value == TMC_MAX && wmode == TMC_WM_NORMAL) begin
            set_fl[TMC_FL_OVF] = 1'b1;
         end else if (at_top && pwm) begin
            set_fl[TMC_FL_OVF] = 1'b1;
         end else if (st_q.count_value == TMC_MAX && wmode == TMC_WM_CTC && !at_top) begin
            set_fl[TMC_FL_OVF] = 1'b1;
         end
         // pwm: load buffered compare at top so a period is never cut short
         if (pwm && at_top) begin
            st_d.cmp_act = st_q.cmp_buf;
         end
         // waveform per channel, output state survives mode changes
         for (int i = 0; i < 2; i++) begin
            com = st_q.ctrl_a[(i == 0 ? TMC_CA_COMA : TMC_CA_COMB) +: 2];
            if (st_q.block) begin
               com = com;
            end else if (pwm) begin
               if (match[i] && com == TMC_COM_CLR) begin
                  st_d.out_st[i] = 1'b0;
               end else if (match[i] && com == TMC_COM_SET) begin
                  st_d.out_st[i] = 1'b1;
               end else if (at_top && com == TMC_COM_CLR) begin
                  st_d.out_st[i] = 1'b1;
               end else if (at_top && com == TMC_COM_SET) begin
                  st_d.out_st[i] = 1'b0;
               end
            end else if (match[i]) begin
               unique case (com)
                  TMC_COM_OFF: st_d.out_st[i] = st_q.out_st[i];
                  TMC_COM_TOG: st_d.out_st[i] = ~st_q.out_st[i];
                  TMC_COM_CLR: st_d.out_st[i] = 1'b0;
                  TMC_COM_SET: st_d.out_st[i] = 1'b1;
               endcase
            end
         end
      end

      // force: acts on the outputs only, counter and flags untouched
      if (force_bit && !pwm) begin
         for (int i = 0; i < 2; i++) begin
            com = st_q.ctrl_a[(i == 0 ? TMC_CA_COMA : TMC_CA_COMB) +: 2];
            if (pwdata[i == 0 ? TMC_CC_FOCA : TMC_CC_FOCB]) begin
               unique case (com)
                  TMC_COM_OFF: st_d.out_st[i] = st_q.out_st[i];
                  TMC_COM_TOG: st_d.out_st[i] = ~st_q.out_st[i];
                  TMC_COM_CLR: st_d.out_st[i] = 1'b0;
                  TMC_COM_SET: st_d.out_st[i] = 1'b1;
               endcase
            end
         end
      end

      // counter write wins over count and clear, and arms match blocking
      if (cnt_wr) begin
         st_d.count_value = pwdata[7:0];
         st_d.block       = 1'b1;
         st_d.match_pend  = 2'b00;
      end

      clr_fl[TMC_FL_OVF]  = clr_fl[TMC_FL_OVF]  | int_ack_ovf;
      clr_fl[TMC_FL_CMPA] = clr_fl[TMC_FL_CMPA] | int_ack_a;
      clr_fl[TMC_FL_CMPB] = clr_fl[TMC_FL_CMPB] | int_ack_b;
      // set beats clear so an event in the clearing cycle survives
      st_d.flags = (st_q.flags & ~clr_fl) | set_fl;
      st_d.irq   = st_d.flags & st_q.mask;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule
`default_nettype wire

/* File: verif/test_timer_counter_8bit_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module test_timer_counter_8bit_compare;
   import tmc_pkg::*;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        ext_count_pin = 1'h0;
   logic        int_ack_a = 1'h0;
   logic        int_ack_b = 1'h0;
   logic        int_ack_ovf = 1'h0;
   logic [31:0] prdata, rd, r1;
   logic        pready, pslverr, er, irq_ovf, irq_cmp_a, irq_cmp_b, wave_out_a, wave_out_b;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          tcyc;
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   tmc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_count_pin(ext_count_pin), .int_ack_a(int_ack_a),
      .int_ack_b(int_ack_b), .int_ack_ovf(int_ack_ovf), .irq_ovf(irq_ovf),
      .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b), .wave_out_a(wave_out_a),
      .wave_out_b(wave_out_b));
   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // one transfer; psel drops for a cycle so no signal is driven twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 40);
      rd = prdata;
      er = pslverr;
      tcyc = cyc;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 40) begin
         check(32'h0, 32'h1);
         report_and_stop();
      end else begin
         @(posedge pclk);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         apb(1'h0, 8'(4 * i), 32'h0);
         check(rd, 32'h0);
      end
      apb(1'h1, TMC_OFF_CMP_A, 32'h1A5);
      apb(1'h0, TMC_OFF_CMP_A, 32'h0);
      check(rd, 32'hA5);
      apb(1'h0, 8'h20, 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
   endtask
   task automatic t_stop_step();
      int t1;
      apb(1'h1, TMC_OFF_COUNT, 32'h5A);
      idle(20);
      apb(1'h0, TMC_OFF_COUNT, 32'h0);
      check(rd, 32'h5A);
      apb(1'h1, TMC_OFF_CTRL_B, 32'h1);
      apb(1'h0, TMC_OFF_COUNT, 32'h0);
      r1 = rd;
      t1 = tcyc;
      apb(1'h0, TMC_OFF_COUNT, 32'h0);
      check(32'(8'(rd - r1)), 32'(8'(tcyc - t1)));
   endtask
   task automatic t_ext();
      for (int k = 0; k < 2; k++) begin
         apb(1'h1, TMC_OFF_CTRL_B, 32'(k == 0 ? TMC_CS_EXT_RISE : TMC_CS_EXT_FALL));
         apb(1'h0, TMC_OFF_COUNT, 32'h0);
         r1 = rd;
         repeat (5) begin
            ext_count_pin <= 1'h1;
            idle(4);
            ext_count_pin <= 1'h0;
            idle(4);
         end
         idle(6);
         apb(1'h0, TMC_OFF_COUNT, 32'h0);
         check(rd, 32'(8'(r1 + 5)));
      end
   endtask
   task automatic t_ovf();
      apb(1'h1, TMC_OFF_CTRL_B, 32'h0);
      apb(1'h1, TMC_OFF_MASK, 32'h1);
      apb(1'h1, TMC_OFF_COUNT, 32'hE0);
      apb(1'h1, TMC_OFF_FLAG, 32'h7);
      apb(1'h1, TMC_OFF_CTRL_B, 32'h1);
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd & 32'h1, 32'h0);
      idle(40);
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd & 32'h1, 32'h1);
      check({31'h0, irq_ovf}, 32'h1);
      apb(1'h0, TMC_OFF_COUNT, 32'h0);
      check({31'h0, rd < 32'h40}, 32'h1);
      apb(1'h1, TMC_OFF_CTRL_B, 32'h0);
      int_ack_ovf <= 1'h1;
      idle(1);
      int_ack_ovf <= 1'h0;
      idle(2);
      check({31'h0, irq_ovf}, 32'h0);
      apb(1'h1, TMC_OFF_FLAG, 32'h7);
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd, 32'h0);
      check({31'h0, irq_ovf}, 32'h0);
   endtask
   task automatic t_block();
      apb(1'h1, TMC_OFF_MASK, 32'h4);
      apb(1'h1, TMC_OFF_CMP_B, 32'h40);
      apb(1'h1, TMC_OFF_COUNT, 32'h40);
      apb(1'h1, TMC_OFF_CTRL_B, 32'h1);
      idle(30);
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd & 32'h4, 32'h0);
      apb(1'h1, TMC_OFF_COUNT, 32'h30);
      idle(40);
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd & 32'h4, 32'h4);
      check({31'h0, irq_cmp_b}, 32'h1);
      apb(1'h1, TMC_OFF_CTRL_B, 32'h0);
      int_ack_b <= 1'h1;
      idle(1);
      int_ack_b <= 1'h0;
      idle(3);
      check({31'h0, irq_cmp_b}, 32'h0);
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd & 32'h4, 32'h0);
   endtask
   task automatic t_ctc();
      apb(1'h1, TMC_OFF_CTRL_A, 32'(TMC_WM_CTC));
      apb(1'h1, TMC_OFF_COUNT, 32'h0);
      apb(1'h1, TMC_OFF_CMP_A, 32'h09);
      apb(1'h0, TMC_OFF_CMP_A, 32'h0);
      check(rd, 32'h09);
      apb(1'h1, TMC_OFF_MASK, 32'h2);
      apb(1'h1, TMC_OFF_CTRL_B, 32'h1);
      repeat (12) begin
         apb(1'h0, TMC_OFF_COUNT, 32'h0);
         check({31'h0, rd <= 32'h09}, 32'h1);
      end
      apb(1'h1, TMC_OFF_CTRL_B, 32'h0);
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd & 32'h2, 32'h2);
      check({31'h0, irq_cmp_a}, 32'h1);
      int_ack_a <= 1'h1;
      idle(1);
      int_ack_a <= 1'h0;
      idle(2);
      check({31'h0, irq_cmp_a}, 32'h0);
   endtask
   // high cycles over 256 pclk span whole periods, so the phase does not matter
   task automatic t_pwm();
      logic [7:0] ca[3];
      logic [7:0] cm[3];
      int         ex[3];
      int         n;
      ca = '{8'h83, 8'hC3, 8'h23};
      cm = '{8'h40, 8'h40, 8'h3F};
      ex = '{65, 191, 36};
      for (int k = 0; k < 3; k++) begin
         apb(1'h1, TMC_OFF_CTRL_B, 32'h0);
         apb(1'h1, TMC_OFF_CTRL_A, 32'(ca[k]));
         apb(1'h1, TMC_OFF_CMP_A, 32'(cm[k]));
         apb(1'h1, TMC_OFF_CMP_B, 32'h08);
         apb(1'h0, TMC_OFF_CMP_A, 32'h0);
         check(rd, 32'(cm[k]));
         apb(1'h1, TMC_OFF_CTRL_B, k == 2 ? 32'h9 : 32'h1);
         idle(600);
         n = 0;
         repeat (256) begin
            @(posedge pclk);
            n += int'((k == 2 ? wave_out_b : wave_out_a) === 1'h1);
         end
         check(32'(n), 32'(ex[k]));
      end
   endtask
   task automatic t_force();
      logic w;
      apb(1'h1, TMC_OFF_CTRL_B, 32'h0);
      w = wave_out_b;
      apb(1'h1, TMC_OFF_CTRL_A, 32'h10);
      check({31'h0, wave_out_b}, {31'h0, w});
      apb(1'h1, TMC_OFF_FLAG, 32'h7);
      apb(1'h0, TMC_OFF_COUNT, 32'h0);
      r1 = rd;
      apb(1'h1, TMC_OFF_CTRL_C, 32'h40);
      idle(2);
      check({31'h0, wave_out_b}, {31'h0, ~w});
      apb(1'h0, TMC_OFF_FLAG, 32'h0);
      check(rd, 32'h0);
      apb(1'h0, TMC_OFF_COUNT, 32'h0);
      check(rd, r1);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_regs();
      t_stop_step();
      t_ext();
      t_ovf();
      t_block();
      t_ctc();
      t_pwm();
      t_force();
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: verif/tmc_timer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_chk (
   input wire logic        pclk,      // system clock
   input wire logic        presetn,   // async reset, low
   input wire logic        psel,      // apb select
   input wire logic        penable,   // apb enable
   input wire logic        pwrite,    // apb direction
   input wire logic [7:0]  paddr,     // apb byte address
   input wire logic [31:0] prdata,    // apb read data
   input wire logic        pready,    // apb ready
   input wire logic        pslverr,   // apb error
   input wire logic        int_ack_b, // compare b serviced
   input wire logic        irq_cmp_b  // compare b request
);
   import tmc_pkg::*;
   // ---------------------------------------------------------------
   // bus and flag relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_wait;
      psel && penable && !pready;
   endsequence
   sequence rd_done;
      psel && penable && pready && !pwrite;
   endsequence
   ready_after_wait_a: assert property (acc_wait |=> pready)
      else $error("pready missing after wait");
   ready_single_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
      else $error("pready without access");
   err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside answer");
   upper_zero_a: assert property (rd_done |-> prdata[31:8] == 24'h0)
      else $error("read data above byte");
   force_reads_zero_a: assert property ((rd_done ##0 paddr == TMC_OFF_CTRL_C)
      |-> prdata == 32'h0)
      else $error("force register read not zero");
   unmapped_zero_a: assert property ((rd_done ##0 pslverr) |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   ack_clears_b_a: assert property (int_ack_b |=> !irq_cmp_b)
      else $error("service did not drop request");
endmodule
bind tmc_timer tmc_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .int_ack_b(int_ack_b), .irq_cmp_b(irq_cmp_b));
`default_nettype wire
